// File: cpu_nmi_model.sv
// cpu side of the watchdog nmi: counts exception entries, keeps level and vector
// assumes the nmi request is a one-cycle pulse on i_mclk
module cpu_nmi_model
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_nmi,
  input  wire logic [2:0]  i_nmi_level,
  input  wire logic [23:0] i_nmi_vector,
  output logic      [7:0]  o_count,
  output logic      [2:0]  o_level,
  output logic      [23:0] o_vector
);
  timeunit 1ns;
  timeprecision 1ps;

  // no mask input here: nothing on this side can hold the request off
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      o_count  <= 8'h00;
      o_level  <= 3'h0;
      o_vector <= 24'h000000;
    end
    else if (i_nmi)
    begin
      o_count  <= o_count + 8'h01;
      o_level  <= i_nmi_level;
      o_vector <= i_nmi_vector;
    end
  end
endmodule : cpu_nmi_model

// File: sub_clock_tick.sv
// rising-edge detector for the low-speed sub-clock pin
// assumes the pin is asynchronous to i_mclk and much slower than it
module sub_clock_tick
(
  input  wire logic i_mclk,
  input  wire logic i_rst,
  input  wire logic i_sub_clk,
  output logic      o_tick
);

  logic [2:0] sync_r;
  logic [2:0] sync_nxt;
  logic       level_r;
  logic       level_nxt;
  logic       tick_r;
  logic       tick_nxt;

  // ---------------------------------------------------------------
  // three-stage sampling, a change counts once stages two and three agree
  // ---------------------------------------------------------------
  always_comb
  begin
    sync_nxt  = {sync_r[1:0], i_sub_clk};
    level_nxt = level_r;
    if (sync_r[1] == sync_r[2])
    begin
      level_nxt = sync_r[2];
    end
    tick_nxt  = level_nxt & ~level_r;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      sync_r  <= 3'h0;
      level_r <= 1'h0;
      tick_r  <= 1'h0;
    end
    else
    begin
      sync_r  <= sync_nxt;
      level_r <= level_nxt;
      tick_r  <= tick_nxt;
    end
  end

  assign o_tick = tick_r;

endmodule : sub_clock_tick

// File: testbench.sv
// self-checking bench for the watchdog timer: apb tasks, sub-clock ticks
// assumes the timeout is shortened to 8 ticks through PERIOD
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import watchdog_nmi_pkg::*;
  localparam int P = 8;
  logic        mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic        sub_clk = 0, sleep = 0, halt = 0;
  logic [15:0] paddr = 16'h0000;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, nmi, irq, err;
  logic [2:0]  lvl, mlvl;
  logic [23:0] vec, mvec;
  logic [7:0]  cnt;
  int          n_errors = 0, compares = 0, cycles = 0;

  always #5 mclk = ~mclk;

  watchdog_nmi_timer #(.PERIOD(P)) DUT
  (
    .i_mclk(mclk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_sub_clk(sub_clk), .i_sleep(sleep), .i_halt(halt), .o_nmi(nmi),
    .o_nmi_level(lvl), .o_nmi_vector(vec), .o_irq(irq)
  );

  cpu_nmi_model cpu
  (
    .i_mclk(mclk), .i_rst(rst), .i_nmi(nmi), .i_nmi_level(lvl), .i_nmi_vector(vec),
    .o_count(cnt), .o_level(mlvl), .o_vector(mvec)
  );

  task automatic report_and_stop;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
    int n;
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk({31'h0, pready}, 32'h1);
  endtask : apb

  task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  // slow sub-clock: one rising edge per call round, stopped between calls
  task automatic ticks(input int n);
    repeat (n)
    begin
      sub_clk <= 1'b1;
      repeat (8) @(posedge mclk);
      sub_clk <= 1'b0;
      repeat (8) @(posedge mclk);
    end
  endtask : ticks

  initial
  begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({29'h0, lvl}, 32'h4);
    chk({8'h0, vec}, 32'h4);
    rdchk(ADDR_WDT_CTRL, 32'h80);
    rdchk(ADDR_IRQ_STATUS, 32'h0);
    rdchk(ADDR_IRQ_MASK, 32'h0);
    $display("test reset done");
    apb(1'b1, ADDR_IRQ_MASK, 32'h1);
    halt <= 1'b1;
    ticks(P - 1);
    chk({24'h0, cnt}, 32'h0);
    ticks(1);
    chk({24'h0, cnt}, 32'h1);
    chk({29'h0, mlvl}, 32'h4);
    chk({8'h0, mvec}, 32'h4);
    chk({31'h0, irq}, 32'h1);
    rdchk(ADDR_IRQ_STATUS, 32'h1);
    apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
    rdchk(ADDR_IRQ_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // mask off: the nmi must still reach the core
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    ticks(P - 1);
    chk({24'h0, cnt}, 32'h1);
    ticks(1);
    chk({24'h0, cnt}, 32'h2);
    chk({31'h0, irq}, 32'h0);
    rdchk(ADDR_IRQ_STATUS, 32'h1);
    $display("test timeout done");
    ticks(5);
    apb(1'b1, ADDR_WDT_CTRL, 32'h84);
    rdchk(ADDR_WDT_CTRL, 32'h80);
    ticks(P - 1);
    chk({24'h0, cnt}, 32'h2);
    ticks(1);
    chk({24'h0, cnt}, 32'h3);
    $display("test restart done");
    ticks(3);
    apb(1'b1, ADDR_WDT_CTRL, 32'h0);
    rdchk(ADDR_WDT_CTRL, 32'h0);
    ticks(2 * P);
    chk({24'h0, cnt}, 32'h3);
    apb(1'b1, ADDR_WDT_CTRL, 32'h80);
    ticks(P - 4);
    chk({24'h0, cnt}, 32'h3);
    ticks(1);
    chk({24'h0, cnt}, 32'h4);
    $display("test disable done");
    // sleep entered right after the last nmi, with the counter back at zero
    sleep <= 1'b1;
    ticks(2 * P);
    sleep <= 1'b0;
    chk({24'h0, cnt}, 32'h4);
    ticks(P - 1);
    chk({24'h0, cnt}, 32'h4);
    ticks(1);
    chk({24'h0, cnt}, 32'h5);
    $display("test sleep done");
    // a write without byte lane zero must not reach the control bits
    pstrb <= 4'h0;
    apb(1'b1, ADDR_WDT_CTRL, 32'h0);
    pstrb <= 4'hF;
    rdchk(ADDR_WDT_CTRL, 32'h80);
    apb(1'b1, 16'hFF4C, 32'h0);
    chk({31'h0, err}, 32'h1);
    rdchk(ADDR_WDT_CTRL, 32'h80);
    apb(1'b1, ADDR_WDT_CTRL, 32'hFF);
    rdchk(ADDR_WDT_CTRL, 32'hF9);
    apb(1'b0, 16'hFF4C, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("test register map done");
    // second reset in mid-run: a stopped watchdog must come back counting
    apb(1'b1, ADDR_WDT_CTRL, 32'h0);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({24'h0, cnt}, 32'h0);
    rdchk(ADDR_WDT_CTRL, 32'h80);
    ticks(P);
    chk({24'h0, cnt}, 32'h1);
    $display("test second reset done");
    report_and_stop();
  end
endmodule : testbench

// File: watchdog_nmi_pkg.sv
// constants shared by the watchdog timer and its testbench
// assumes a 16-bit APB byte address and 32-bit APB data
package watchdog_nmi_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [15:0] ADDR_WDT_CTRL   = 16'hFF40;
  localparam logic [15:0] ADDR_IRQ_STATUS = 16'hFF44;
  localparam logic [15:0] ADDR_IRQ_MASK   = 16'hFF48;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int          BIT_WATCHDOG_ENABLE   = 7;
  localparam int          BIT_CLOCK_OUT_SEL2    = 6;
  localparam int          BIT_CLOCK_OUT_SEL0    = 4;
  localparam int          BIT_CLOCK_OUT_ON      = 3;
  localparam int          BIT_WATCHDOG_RESTART  = 2;
  localparam int          BIT_SECOND_TIMER_RST  = 1;
  localparam int          BIT_SECOND_TIMER_RUN  = 0;
  localparam logic [7:0]  CTRL_RESET            = 8'h80;
  // bits that store what software writes; restart and timer reset read zero
  localparam logic [7:0]  CTRL_STORED_MASK      = 8'hF9;

  // ---------------------------------------------------------------
  // interrupt status / mask fields
  // ---------------------------------------------------------------
  localparam int          BIT_IRQ_TIMEOUT       = 0;
  localparam logic [0:0]  IRQ_MASK_RESET        = 1'h0;

  // ---------------------------------------------------------------
  // timeout and nmi constants
  // ---------------------------------------------------------------
  localparam int          PERIOD_SUB_CLOCKS     = 131072;
  localparam int          COUNT_W               = 18;
  localparam logic [2:0]  NMI_LEVEL             = 3'h4;
  localparam logic [23:0] NMI_VECTOR            = 24'h000004;

endpackage : watchdog_nmi_pkg

// File: watchdog_nmi_timer.sv
// watchdog timer counting sub-clock periods, raising an nmi on timeout
// assumes an APB master on i_mclk and a sleep flag from the clock controller
//
// Local design decision: the APB interface to the registers.
module watchdog_nmi_timer
  import watchdog_nmi_pkg::*;
#(
  parameter int PERIOD = watchdog_nmi_pkg::PERIOD_SUB_CLOCKS
)
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [15:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_sub_clk,
  input  wire logic        i_sleep,
  input  wire logic        i_halt,
  output logic             o_nmi,
  output logic      [2:0]  o_nmi_level,
  output logic      [23:0] o_nmi_vector,
  output logic             o_irq
);
  import watchdog_nmi_pkg::*;

  localparam logic [COUNT_W-1:0] LAST_COUNT = COUNT_W'(PERIOD - 1);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic is_mapped(input logic [15:0] addr);
    is_mapped = (addr == ADDR_WDT_CTRL) || (addr == ADDR_IRQ_STATUS) ||
                (addr == ADDR_IRQ_MASK);
  endfunction : is_mapped

  logic               tick;
  logic [7:0]         ctrl_r;
  logic [7:0]         ctrl_nxt;
  logic [COUNT_W-1:0] count_r;
  logic [COUNT_W-1:0] count_nxt;
  logic               nmi_r;
  logic               nmi_nxt;
  logic               status_r;
  logic               status_nxt;
  logic               mask_r;
  logic               mask_nxt;
  logic               irq_r;
  logic               irq_nxt;
  logic [31:0]        prdata_r;
  logic [31:0]        prdata_nxt;
  logic               pready_r;
  logic               pready_nxt;
  logic               pslverr_r;
  logic               pslverr_nxt;
  logic               access;
  logic               wr_ctrl;
  logic               wr_status;
  logic               wr_mask;
  logic               restart;
  logic               timeout;

  sub_clock_tick u_tick
  (
    .i_mclk    (i_mclk),
    .i_rst     (i_rst),
    .i_sub_clk (i_sub_clk),
    .o_tick    (tick)
  );

  // ---------------------------------------------------------------
  // apb slave: one wait state, pready from a flop
  // ---------------------------------------------------------------
  assign access    = i_psel & i_penable & pready_r;
  assign wr_ctrl   = access & i_pwrite & i_pstrb[0] & (i_paddr == ADDR_WDT_CTRL);
  assign wr_status = access & i_pwrite & i_pstrb[0] & (i_paddr == ADDR_IRQ_STATUS);
  assign wr_mask   = access & i_pwrite & i_pstrb[0] & (i_paddr == ADDR_IRQ_MASK);

  always_comb
  begin
    pready_nxt  = i_psel & i_penable & ~pready_r;
    pslverr_nxt = pready_nxt & ~is_mapped(i_paddr);
    prdata_nxt  = 32'h0;
    if (pready_nxt & ~i_pwrite)
    begin
      unique case (i_paddr)
        ADDR_WDT_CTRL:   prdata_nxt[7:0] = ctrl_r & CTRL_STORED_MASK;
        ADDR_IRQ_STATUS: prdata_nxt[BIT_IRQ_TIMEOUT] = status_r;
        ADDR_IRQ_MASK:   prdata_nxt[BIT_IRQ_TIMEOUT] = mask_r;
        default:         prdata_nxt = 32'h0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl)
    begin
      ctrl_nxt = i_pwdata[7:0] & CTRL_STORED_MASK;
    end
  end

  assign restart = wr_ctrl & i_pwdata[BIT_WATCHDOG_RESTART];

  // ---------------------------------------------------------------
  // watchdog counter
  // ---------------------------------------------------------------
  // halt is deliberately not a term here: a stuck halt must still time out
  // count every rising sub-clock edge while enabled and not in sleep
  assign timeout = ctrl_r[BIT_WATCHDOG_ENABLE] & ~i_sleep & tick & ~restart &
                   (count_r == LAST_COUNT);

  always_comb
  begin
    count_nxt = count_r;
    nmi_nxt   = 1'h0;
    if (restart)
    begin
      count_nxt = '0;
    end
    else if (ctrl_r[BIT_WATCHDOG_ENABLE] & ~i_sleep & tick)
    begin
      if (timeout)
      begin
        count_nxt = '0;
        nmi_nxt   = 1'h1;
      end
      else
      begin
        count_nxt = count_r + COUNT_W'(1);
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt status and mask, set wins over clear
  // ---------------------------------------------------------------
  always_comb
  begin
    status_nxt = status_r;
    mask_nxt   = mask_r;
    if (wr_status & i_pwdata[BIT_IRQ_TIMEOUT])
    begin
      status_nxt = 1'h0;
    end
    if (timeout)
    begin
      status_nxt = 1'h1;
    end
    if (wr_mask)
    begin
      mask_nxt = i_pwdata[BIT_IRQ_TIMEOUT];
    end
    irq_nxt = status_nxt & mask_nxt;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      ctrl_r    <= CTRL_RESET;
      count_r   <= '0;
      nmi_r     <= 1'h0;
      status_r  <= 1'h0;
      mask_r    <= IRQ_MASK_RESET;
      irq_r     <= 1'h0;
      prdata_r  <= 32'h0;
      pready_r  <= 1'h0;
      pslverr_r <= 1'h0;
    end
    else
    begin
      ctrl_r    <= ctrl_nxt;
      count_r   <= count_nxt;
      nmi_r     <= nmi_nxt;
      status_r  <= status_nxt;
      mask_r    <= mask_nxt;
      irq_r     <= irq_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  logic [2:0]  level_r;
  logic [23:0] vector_r;

  // fixed priority level and vector toward the core
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      level_r  <= 3'h0;
      vector_r <= 24'h0;
    end
    else
    begin
      level_r  <= NMI_LEVEL;
      vector_r <= NMI_VECTOR;
    end
  end

  assign o_prdata     = prdata_r;
  assign o_pready     = pready_r;
  assign o_pslverr    = pslverr_r;
  // nmi pulse is independent of the irq mask
  assign o_nmi        = nmi_r;
  assign o_nmi_level  = level_r;
  assign o_nmi_vector = vector_r;
  assign o_irq        = irq_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_timeout_nmi: assert property (@(posedge i_mclk) disable iff (i_rst)
    timeout |=> o_nmi && count_r == '0)
    else $error("timeout did not raise nmi");

  a_nmi_cause: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_nmi |-> $past(count_r) == LAST_COUNT && $past(tick))
    else $error("nmi without full period");

  a_reset_enable: assert property (@(posedge i_mclk)
    $fell(i_rst) |-> ctrl_r[BIT_WATCHDOG_ENABLE])
    else $error("watchdog not enabled after reset");

  a_halt_counts: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_halt && ~i_sleep && tick && ctrl_r[BIT_WATCHDOG_ENABLE] && ~restart &&
    count_r != LAST_COUNT |=> count_r == $past(count_r) + COUNT_W'(1))
    else $error("counter stopped during halt");

  a_sleep_freeze: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_sleep && ~restart |=> $stable(count_r) && ~o_nmi)
    else $error("counter moved in sleep");

  a_nmi_level: assert property (@(posedge i_mclk) disable iff (i_rst)
    $past(~i_rst) |-> o_nmi_level == NMI_LEVEL && o_nmi_vector == NMI_VECTOR)
    else $error("nmi level or vector wrong");

  a_disable_quiet: assert property (@(posedge i_mclk) disable iff (i_rst)
    ~ctrl_r[BIT_WATCHDOG_ENABLE] && ~restart |=> $stable(count_r) && ~o_nmi)
    else $error("disabled watchdog active");

  a_restart_clear: assert property (@(posedge i_mclk) disable iff (i_rst)
    restart |=> count_r == '0 ##0 ~ctrl_r[BIT_WATCHDOG_RESTART])
    else $error("restart did not clear count");

  a_wrap_zero: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_nmi |-> count_r == '0 ##1 ~o_nmi [*2])
    else $error("nmi held more than one cycle");

  a_irq_sticky: assert property (@(posedge i_mclk) disable iff (i_rst)
    timeout ##1 mask_r |-> o_irq ##0 status_r)
    else $error("status not set by timeout");

  c_timeout:   cover property (@(posedge i_mclk) disable iff (i_rst) o_nmi);
  c_restart:   cover property (@(posedge i_mclk) disable iff (i_rst) restart ##1 tick);
  c_sleep:     cover property (@(posedge i_mclk) disable iff (i_rst) i_sleep && tick);
  c_irq_clear: cover property (@(posedge i_mclk) disable iff (i_rst) $fell(o_irq));

endmodule : watchdog_nmi_timer
